// ===== core/sfq_top.sv
// forwarding and qos configuration registers with their frame-side decisions
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "sfq_consts.svh"
module sfq_top #(
  parameter int CYC_SHORT = `SFQ_PERIOD_SHORT_MS * `SFQ_CLK_KHZ,
  parameter int CYC_MID   = `SFQ_PERIOD_MID_MS * `SFQ_CLK_KHZ,
  parameter int CYC_LONG  = `SFQ_PERIOD_LONG_MS * `SFQ_CLK_KHZ
) (
  // clock and reset
  input  wire logic                       CLK_SYS,
  input  wire logic                       RESET,
  // apb slave
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [11:0]                PADDR,
  input  wire logic [31:0]                PWDATA,
  output logic      [31:0]                PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  // unknown ip multicast decision
  input  wire logic                       MC_REQ_VALID,
  input  wire sfq_pkg::sfq_mcast_req_type MC_REQ,
  output logic                            MC_RES_VALID,
  output sfq_pkg::sfq_mcast_res_type      MC_RES,
  // rate limiting controls
  output logic      [1:0]                 RATE_PERIOD_SEL,
  output logic                            RATE_PERIOD_TICK,
  output logic                            EGRESS_QUEUE_MODE,
  // default tag insertion decision
  input  wire logic                       TAG_REQ_VALID,
  input  wire sfq_pkg::sfq_tag_req_type   TAG_REQ,
  input  wire logic [4:0]                 CTRL0_TAG_INSERT,
  input  wire logic [24:0]                CTRL8_TAG_INSERT,
  output logic                            TAG_RES_VALID,
  output logic                            TAG_INSERT,
  // traffic-class priority lookup
  input  wire logic                       PRIO_REQ_VALID,
  input  wire logic [7:0]                 PRIO_TC,
  output logic                            PRIO_RES_VALID,
  output logic      [1:0]                 PRIO_VALUE
);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  ////////////////////////////////////////////////////////////////
  // register state
  logic       uipm_en;
  logic [4:0] uipm_map;
  logic [1:0] period;
  logic       queue_mode;
  logic       srctag_sel;
  logic       next_uipm_en;
  logic [4:0] next_uipm_map;
  logic [1:0] next_period;
  logic       next_queue_mode;
  logic       next_srctag_sel;

  // bus decode
  logic [7:0]  idx;
  logic        addr_ok;
  logic        hit_uipm;
  logic        hit_rltc;
  logic        hit_prio;
  logic        access;
  logic        wr_commit;
  logic [3:0]  prio_idx;
  logic [7:0]  mem_rd_data;
  logic [7:0]  mem_lk_data;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // apb word index; upper and lane address bits must be zero
  always_comb begin
    idx       = PADDR[9:2];
    addr_ok   = PADDR[1:0] == 2'h0 && PADDR[11:10] == 2'h0;
    hit_uipm  = addr_ok && idx == `SFQ_IDX_UIPM;
    hit_rltc  = addr_ok && idx == `SFQ_IDX_RLTC;
    hit_prio  = addr_ok && idx >= `SFQ_IDX_PRIO_BASE
                && idx < 8'(`SFQ_IDX_PRIO_BASE + `SFQ_PRIO_REGS);
    prio_idx  = 4'(idx - `SFQ_IDX_PRIO_BASE);
    access    = PSEL && PENABLE;
    // writes land only at the edge where the master sees pready
    wr_commit = access && PREADY && PWRITE;
  end

  ////////////////////////////////////////////////////////////////
  // priority table storage
  sfq_prio_mem #(
    .DEPTH (`SFQ_PRIO_REGS),
    .AW    (4),
    .DW    (8)
  ) u_prio_mem (
    .clk     (CLK_SYS),
    .reset   (RESET),
    .wr_en   (wr_commit && hit_prio),
    .wr_addr (prio_idx),
    .wr_data (PWDATA[7:0]),
    .rd_addr (prio_idx),
    .rd_data (mem_rd_data),
    .lk_addr (PRIO_TC[7:4]),
    .lk_data (mem_lk_data)
  );

  ////////////////////////////////////////////////////////////////
  // apb answer: one wait state so the table read comes from a flop
  always_comb begin
    next_pready  = access && !PREADY;
    next_prdata  = PREADY ? 32'h0000_0000 : PRDATA;
    next_pslverr = 1'b0;
    if (access && !PREADY) begin
      next_pslverr = !(hit_uipm || hit_rltc || hit_prio);
      if (hit_uipm) begin
        next_prdata = {26'h0, uipm_en, uipm_map};
      end else if (hit_rltc) begin
        next_prdata = {26'h0, period, queue_mode, srctag_sel, 2'h0};
      end else if (hit_prio) begin
        next_prdata = {24'h0, mem_rd_data};
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    PREADY  <= RESET ? 1'b0 : next_pready;
    PRDATA  <= RESET ? 32'h0000_0000 : next_prdata;
    PSLVERR <= RESET ? 1'b0 : next_pslverr;
  end

  ////////////////////////////////////////////////////////////////
  // control registers; reserved bits are never stored
  always_comb begin
    next_uipm_en    = uipm_en;
    next_uipm_map   = uipm_map;
    next_period     = period;
    next_queue_mode = queue_mode;
    next_srctag_sel = srctag_sel;
    if (wr_commit && hit_uipm) begin
      next_uipm_en  = PWDATA[`SFQ_UIPM_EN_BIT];
      next_uipm_map = PWDATA[4:0];
    end
    if (wr_commit && hit_rltc) begin
      next_period     = PWDATA[`SFQ_RLTC_PERIOD_LSB +: 2];
      next_queue_mode = PWDATA[`SFQ_RLTC_QUEUE_BIT];
      next_srctag_sel = PWDATA[`SFQ_RLTC_SRCTAG_BIT];
    end
  end

  // reset words held as vectors, a bare literal cannot be bit-selected
  localparam logic [7:0] uipm_rst = `SFQ_UIPM_RESET;
  localparam logic [7:0] rltc_rst = `SFQ_RLTC_RESET;

  // map and enable reset to zero
  always_ff @(posedge CLK_SYS) begin
    uipm_en    <= RESET ? uipm_rst[`SFQ_UIPM_EN_BIT] : next_uipm_en;
    uipm_map   <= RESET ? uipm_rst[4:0] : next_uipm_map;
    period     <= RESET ? rltc_rst[`SFQ_RLTC_PERIOD_LSB +: 2] : next_period;
    queue_mode <= RESET ? rltc_rst[`SFQ_RLTC_QUEUE_BIT] : next_queue_mode;
    srctag_sel <= RESET ? rltc_rst[`SFQ_RLTC_SRCTAG_BIT] : next_srctag_sel;
  end

  ////////////////////////////////////////////////////////////////
  // rate limit controls
  sfq_period_timer #(
    .CYC_SHORT (CYC_SHORT),
    .CYC_MID   (CYC_MID),
    .CYC_LONG  (CYC_LONG),
    .CW        (27)
  ) u_period_timer (
    .clk   (CLK_SYS),
    .reset (RESET),
    .sel   (period),
    .tick  (RATE_PERIOD_TICK)
  );

  // period code normalised, 1x reported as the long period
  // queue mode straight from its control bit
  always_ff @(posedge CLK_SYS) begin
    RATE_PERIOD_SEL   <= RESET ? sfq_pkg::SFQ_PERIOD_64 :
                         (period[1] ? sfq_pkg::SFQ_PERIOD_256 : period);
    EGRESS_QUEUE_MODE <= RESET ? 1'b0 : queue_mode;
  end

  ////////////////////////////////////////////////////////////////
  // unknown ip multicast decision
  sfq_pkg::sfq_mcast_res_type next_mc_res;

  always_comb begin
    // only a frame whose group missed the table is unknown
    // the map is ignored while the enable is clear
    next_mc_res.apply = MC_REQ_VALID && uipm_en && MC_REQ.is_ip && !MC_REQ.group_hit;
    next_mc_res.drop  = next_mc_res.apply && uipm_map == 5'h00;
    next_mc_res.ports = next_mc_res.apply ? uipm_map : 5'h00;
  end

  always_ff @(posedge CLK_SYS) begin
    MC_RES_VALID <= RESET ? 1'b0 : MC_REQ_VALID;
    MC_RES       <= RESET ? '0 : next_mc_res;
  end

  ////////////////////////////////////////////////////////////////
  // default tag insertion decision
  logic [4:0] tag_bit;
  logic       tag_ports_ok;
  logic       next_tag_insert;

  always_comb begin
    // widen before the product, a 3-bit product would wrap
    tag_bit      = 5'(TAG_REQ.egr_port) * 5'd5 + 5'(TAG_REQ.src_port);
    // port numbers of five and above never insert
    tag_ports_ok = TAG_REQ.egr_port < 3'd5 && TAG_REQ.src_port < 3'd5;
    next_tag_insert = 1'b0;
    if (tag_ports_ok) begin
      // per-source choice of the egress port
      // one bit per egress port for every source
      next_tag_insert = srctag_sel ? CTRL8_TAG_INSERT[tag_bit] : CTRL0_TAG_INSERT[TAG_REQ.egr_port];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    TAG_RES_VALID <= RESET ? 1'b0 : TAG_REQ_VALID;
    TAG_INSERT    <= RESET ? 1'b0 : next_tag_insert;
  end

  ////////////////////////////////////////////////////////////////
  // priority lookup: byte fetched by code[5:2], field picked by code[1:0]
  logic       lk_valid;
  logic [1:0] lk_field;
  logic [1:0] next_prio_value;

  // upper six bits of the traffic-class byte form the code
  always_ff @(posedge CLK_SYS) begin
    lk_valid <= RESET ? 1'b0 : PRIO_REQ_VALID;
    lk_field <= RESET ? 2'h0 : PRIO_TC[3:2];
  end

  // code n reads table bits [2n+1:2n]
  // code zero lands on bits 1:0 of the first register
  always_comb begin
    next_prio_value = mem_lk_data[{lk_field, 1'b0} +: 2];
  end

  always_ff @(posedge CLK_SYS) begin
    PRIO_RES_VALID <= RESET ? 1'b0 : lk_valid;
    PRIO_VALUE     <= RESET ? 2'h0 : next_prio_value;
  end

  ////////////////////////////////////////////////////////////////
  // checks
  sequence s_unknown_ip;
    MC_REQ_VALID && MC_REQ.is_ip && !MC_REQ.group_hit && uipm_en;
  endsequence

  sequence s_prio_code_zero;
    PRIO_REQ_VALID && PRIO_TC[7:2] == 6'h00;
  endsequence

  a_mcast_empty_drop: assert property (
    s_unknown_ip and (uipm_map == 5'h00) |=> MC_RES.drop && MC_RES.ports == 5'h00)
    else $error("empty map did not discard unknown ip multicast");

  a_mcast_port_map: assert property (
    s_unknown_ip |=> MC_RES.apply && MC_RES.ports == $past(uipm_map))
    else $error("forward ports differ from the map");

  a_mcast_enable_gate: assert property (
    MC_REQ_VALID && !uipm_en |=> MC_RES_VALID && !MC_RES.apply)
    else $error("map applied while disabled");

  a_mcast_known_group: assert property (
    MC_REQ_VALID && MC_REQ.group_hit |=> !MC_RES.apply && !MC_RES.drop)
    else $error("known group treated as unknown");

  a_period_code: assert property (
    ##1 RATE_PERIOD_SEL == ($past(period[1]) ? 2'b10 : $past(period)))
    else $error("period select does not follow the code");

  a_egress_mode: assert property (
    wr_commit && hit_rltc |=> ##1 EGRESS_QUEUE_MODE == $past(PWDATA[`SFQ_RLTC_QUEUE_BIT], 2))
    else $error("egress mode not taken from written bit");

  a_tag_per_source: assert property (
    TAG_REQ_VALID && srctag_sel && tag_ports_ok |=> TAG_RES_VALID && TAG_INSERT == $past(CTRL8_TAG_INSERT[tag_bit]))
    else $error("tag decision ignored per-source setting");

  a_tag_per_egress: assert property (
    TAG_REQ_VALID && !srctag_sel && tag_ports_ok
    |=> TAG_INSERT == $past(CTRL0_TAG_INSERT[TAG_REQ.egr_port]))
    else $error("tag decision ignored egress control bit");

  a_prio_latency: assert property (
    PRIO_REQ_VALID |-> ##2 PRIO_RES_VALID)
    else $error("priority answer not two cycles after request");

  a_prio_field: assert property (
    lk_valid |=> PRIO_VALUE == ($past(mem_lk_data >> {lk_field, 1'b0}) & 8'h03))
    else $error("priority taken from wrong field");

  a_prio_code_zero: assert property (
    s_prio_code_zero ##1 1'b1 |=> PRIO_VALUE == $past(mem_lk_data[1:0]))
    else $error("code zero did not use bits 1:0");

  a_reserved_zero: assert property (
    PREADY && !PWRITE && hit_rltc |-> PRDATA[7:6] == 2'h0 && PRDATA[1:0] == 2'h0 && PRDATA[31:8] == 24'h0)
    else $error("reserved bits read nonzero");

endmodule
`default_nettype wire

// ===== core/sfq_consts.svh
// offsets, field positions, reset values and timing counts of the forwarding/qos config block
// Function
// - an all-zero unknown ip multicast port map discards such frames, and the map resets to zero.
// - each set map bit (bit 0 is port 1) sends unknown ip multicast frames to that port, all ones to every port.
// - the port map is applied only while its enable bit is one.
// - the ingress rate period code selects 16 ms for 00, 64 ms for 01 and 256 ms for 1x.
// - the egress rate limiter works per port when the queue select bit is zero and per queue when it is one.
// - with source tag selection at one, tag insertion per egress port follows that port's per-source settings.
// - with source tag selection at zero, tag insertion follows bit 2 of the egress port's first control register.
// - the priority table is 64 two-bit fields held in sixteen consecutive byte registers.
// - the upper six bits of the traffic-class byte select one of the 64 table fields.
// - code n takes table bits [2n+1:2n] as the frame priority.
// - code zero takes its priority from bits 1:0 of the first priority register.
`ifndef SFQ_CONSTS_SVH
`define SFQ_CONSTS_SVH

// register indices; byte address is four times the index
`define SFQ_IDX_UIPM        8'h86
`define SFQ_IDX_RLTC        8'h87
`define SFQ_IDX_PRIO_BASE   8'h90
`define SFQ_PRIO_REGS       16

// field positions
`define SFQ_UIPM_EN_BIT     5
`define SFQ_RLTC_PERIOD_LSB 4
`define SFQ_RLTC_QUEUE_BIT  3
`define SFQ_RLTC_SRCTAG_BIT 2

// reset values
`define SFQ_UIPM_RESET      8'h00
`define SFQ_RLTC_RESET      8'h10
`define SFQ_PRIO_RESET      8'h00

// timing
`define SFQ_CLK_KHZ         250000
`define SFQ_PERIOD_SHORT_MS 16
`define SFQ_PERIOD_MID_MS   64
`define SFQ_PERIOD_LONG_MS  256

`endif

// ===== core/sfq_pkg.sv
// types shared by the forwarding/qos config block
package sfq_pkg;

  // ingress rate measurement period codes
  typedef enum logic [1:0] {
    SFQ_PERIOD_16  = 2'b00,
    SFQ_PERIOD_64  = 2'b01,
    SFQ_PERIOD_256 = 2'b10
  } sfq_period_type;

  // multicast lookup request and result
  typedef struct packed {
    logic is_ip;
    logic group_hit;
  } sfq_mcast_req_type;

  typedef struct packed {
    logic       apply;
    logic       drop;
    logic [4:0] ports;
  } sfq_mcast_res_type;

  // tag insertion query, port numbers 0..4 stand for ports 1..5
  typedef struct packed {
    logic [2:0] src_port;
    logic [2:0] egr_port;
  } sfq_tag_req_type;

endpackage

// ===== core/sfq_prio_mem.sv
// priority table storage: byte registers with a bus read port and a lookup read port
`timescale 1ns/1ns
`default_nettype none
`include "sfq_consts.svh"
module sfq_prio_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int DW    = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read ports, data one cycle after the address
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data,
  input  wire logic [AW-1:0] lk_addr,
  output logic      [DW-1:0] lk_data
);

  logic [DW-1:0] mem      [DEPTH];
  logic [DW-1:0] next_mem [DEPTH];

  ////////////////////////////////////////////////////////////////
  // one byte register per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_comb begin
      next_mem[i] = mem[i];
      if (wr_en && wr_addr == AW'(i)) begin
        next_mem[i] = wr_data;
      end
    end
    always_ff @(posedge clk) begin
      mem[i] <= reset ? DW'(`SFQ_PRIO_RESET) : next_mem[i];
    end
  end

  ////////////////////////////////////////////////////////////////
  // registered reads; a same-cycle write shows on the next read
  always_ff @(posedge clk) begin
    rd_data <= reset ? '0 : mem[rd_addr];
    lk_data <= reset ? '0 : mem[lk_addr];
  end

  a_lookup_read_data: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> lk_data == $past(mem[lk_addr]))
    else $error("lookup read data does not match table entry");

endmodule
`default_nettype wire

// ===== core/sfq_period_timer.sv
// ingress rate measurement period ticker
`timescale 1ns/1ns
`default_nettype none
module sfq_period_timer #(
  parameter int CYC_SHORT = 4000000,
  parameter int CYC_MID   = 16000000,
  parameter int CYC_LONG  = 64000000,
  parameter int CW        = 27
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // period code and end-of-period pulse
  input  wire logic [1:0] sel,
  output logic            tick
);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] limit;
  logic          next_tick;

  ////////////////////////////////////////////////////////////////
  // 00 short, 01 mid, either code with bit 1 set long
  always_comb begin
    limit = sel[1] ? CW'(CYC_LONG - 1) : (sel[0] ? CW'(CYC_MID - 1) : CW'(CYC_SHORT - 1));
    // a shortened period wraps at once instead of running past
    next_tick = cnt >= limit;
    next_cnt  = next_tick ? '0 : cnt + CW'(1);
  end

  always_ff @(posedge clk) begin
    cnt  <= reset ? '0 : next_cnt;
    tick <= reset ? 1'b0 : next_tick;
  end

  // tick follows the count reaching the selected length
  a_period_wrap: assert property (@(posedge clk) disable iff (reset)
    (cnt == limit) |=> tick && cnt == '0)
    else $error("period did not end at selected length");

endmodule
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the forwarding and qos configuration block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                       clk_sys, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata;
  logic                       mc_v, mc_rv, tag_v, tag_rv, tag_ins, prio_v, prio_rv, rate_tick, eq_mode;
  sfq_pkg::sfq_mcast_req_type mc_req;
  sfq_pkg::sfq_mcast_res_type mc_res;
  sfq_pkg::sfq_tag_req_type   tag_req;
  logic [4:0]                 ctrl0;
  logic [24:0]                ctrl8;
  logic [7:0]                 prio_tc;
  logic [1:0]                 rate_sel, prio_val;
  logic [31:0]                d;
  logic                       e;
  int                         n_fail, checked, n;
  // one multicast row: port map register value, frame kind, expected decision
  typedef struct packed {
    logic [7:0]                 wv;
    logic                       ip;
    logic                       hit;
    sfq_pkg::sfq_mcast_res_type exp;
  } sfq_mc_row_type;
  sfq_mc_row_type rows [8] = '{
    '{8'h20, 1'h1, 1'h0, 7'h60}, '{8'h21, 1'h1, 1'h0, 7'h41}, '{8'h2f, 1'h1, 1'h0, 7'h4f},
    '{8'h3f, 1'h1, 1'h0, 7'h5f}, '{8'h1f, 1'h1, 1'h0, 7'h00}, '{8'h3f, 1'h1, 1'h1, 7'h00},
    '{8'h3f, 1'h0, 1'h0, 7'h00}, '{8'hff, 1'h1, 1'h0, 7'h5f}};
  int per [4] = '{8, 16, 32, 32};

  // short periods keep the tick checks within a few hundred cycles
  sfq_top #(.CYC_SHORT(8), .CYC_MID(16), .CYC_LONG(32)) u_dut (
    .CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MC_REQ_VALID(mc_v), .MC_REQ(mc_req), .MC_RES_VALID(mc_rv), .MC_RES(mc_res),
    .RATE_PERIOD_SEL(rate_sel), .RATE_PERIOD_TICK(rate_tick), .EGRESS_QUEUE_MODE(eq_mode),
    .TAG_REQ_VALID(tag_v), .TAG_REQ(tag_req), .CTRL0_TAG_INSERT(ctrl0), .CTRL8_TAG_INSERT(ctrl8),
    .TAG_RES_VALID(tag_rv), .TAG_INSERT(tag_ins), .PRIO_REQ_VALID(prio_v), .PRIO_TC(prio_tc),
    .PRIO_RES_VALID(prio_rv), .PRIO_VALUE(prio_val));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 4 ns period
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic end_of_test;
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // apb transfer; request held until pready is seen, released at the taking edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'h1;
    k = 0;
    // pready, read data and error are all taken at the edge that ends the transfer
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) begin
      n_fail++;
      end_of_test();
    end
    d = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'h0, idx, 8'h00);
    chk(name, {24'h0, exp}, d);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask

  // one-cycle query, answer one cycle later (plus one extra cycle for the priority path)
  task automatic query(input int kind, input int lat);
    @(posedge clk_sys);
    mc_v <= (kind == 0);
    tag_v <= (kind == 1);
    prio_v <= (kind == 2);
    @(posedge clk_sys);
    mc_v <= 1'h0;
    tag_v <= 1'h0;
    prio_v <= 1'h0;
    repeat (lat - 1) @(posedge clk_sys);
    #1;
  endtask

  task automatic tagq(input logic [2:0] s, input logic [2:0] eg, input logic exp);
    tag_req <= '{src_port: s, egr_port: eg};
    query(1, 1);
    chk("tag_valid", 32'h1, {31'h0, tag_rv});
    chk("tag_insert", {31'h0, exp}, {31'h0, tag_ins});
  endtask

  task automatic prioq(input logic [5:0] code, input logic [1:0] exp);
    prio_tc <= {code, 2'h3};
    query(2, 2);
    chk("prio_valid", 32'h1, {31'h0, prio_rv});
    chk("prio_value", {30'h0, exp}, {30'h0, prio_val});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard well beyond the longest sequence
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  initial begin
    {reset, psel, penable, pwrite, mc_v, tag_v, prio_v} = 7'h40;
    {paddr, pwdata, ctrl0, ctrl8, prio_tc} = '0;
    mc_req = '0;
    tag_req = '0;
    n_fail = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'h0;
    // multicast rows: map readback with reserved bits cleared, then the decision
    foreach (rows[i]) begin
      apb(1'h1, 8'h86, rows[i].wv);
      rdc("uipm_reg", 8'h86, rows[i].wv & 8'h3f);
      mc_req <= '{is_ip: rows[i].ip, group_hit: rows[i].hit};
      query(0, 1);
      chk("mc_valid", 32'h1, {31'h0, mc_rv});
      chk("mc_res", {25'h0, rows[i].exp}, {25'h0, mc_res});
    end
    // period codes, tick spacing measured between two ticks
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, 8'h87, 8'(c << 4) | 8'h08);
      // register lands at the taking edge, the output flop one edge later
      repeat (2) @(posedge clk_sys);
      chk("period_sel", (c > 1) ? 32'h2 : 32'(c), {30'h0, rate_sel});
      chk("queue_mode", 32'h1, {31'h0, eq_mode});
      for (int p = 0; p < 2; p++) begin
        n = 0;
        do begin
          @(posedge clk_sys);
          #1;
          n++;
        end while (rate_tick !== 1'h1 && n < 200);
      end
      chk("tick_spacing", 32'(per[c]), 32'(n));
    end
    // tag source: per source settings, then the egress port's own bit
    ctrl8 <= 25'h0002000;
    ctrl0 <= 5'h1b;
    apb(1'h1, 8'h87, 8'hff);
    rdc("rltc_reg", 8'h87, 8'h3c);
    tagq(3'h3, 3'h2, 1'h1);
    tagq(3'h2, 3'h2, 1'h0);
    apb(1'h1, 8'h87, 8'h10);
    repeat (2) @(posedge clk_sys);
    chk("queue_mode", 32'h0, {31'h0, eq_mode});
    tagq(3'h3, 3'h2, 1'h0);
    tagq(3'h3, 3'h1, 1'h1);
    // priority table: first and last byte, low traffic-class bits ignored
    apb(1'h1, 8'h90, 8'he4);
    apb(1'h1, 8'h9f, 8'h1b);
    rdc("prio_reg0", 8'h90, 8'he4);
    for (int c = 0; c < 4; c++) begin
      prioq(6'(c), 2'(c));
      prioq(6'(60 + c), 2'(3 - c));
    end
    // unmapped word is refused and changes nothing
    apb(1'h1, 8'h88, 8'hff);
    chk("unmapped_err", 32'h1, {31'h0, e});
    rdc("rltc_reg", 8'h87, 8'h10);
    // move every control field off its default so the reset has work to do
    apb(1'h1, 8'h87, 8'h2c);
    // second reset in mid-run restores every default
    @(posedge clk_sys);
    reset <= 1'h1;
    repeat (16) @(posedge clk_sys);
    reset <= 1'h0;
    #1;
    chk("period_sel", 32'h1, {30'h0, rate_sel});
    chk("queue_mode", 32'h0, {31'h0, eq_mode});
    rdc("uipm_reg", 8'h86, 8'h00);
    rdc("rltc_reg", 8'h87, 8'h10);
    rdc("prio_reg0", 8'h90, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
